/* core/dic_top.sv */
// Purpose: status contact input conditioner with element enable logic
// Assumes: contact and button pins are asynchronous, the rest is on clk
// Notes:   registers on AHB-Lite, reads take one wait state
module dic_top #(
  parameter int TICK_CYC = dic_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic [dic_pkg::NIN-1:0] contact_inputs,
  input wire logic [9:0] vdc_volts,
  input wire logic [dic_pkg::NEL-1:0] panel_on,
  input wire logic [dic_pkg::NEL-1:0] panel_off,
  input wire logic [dic_pkg::NEL-1:0] elem_sig_raw,
  output logic [dic_pkg::NIN-1:0] di_value,
  output logic [dic_pkg::NIN-1:0] di_valid,
  output logic [dic_pkg::NLOG-1:0] logic_in,
  output logic [dic_pkg::NEL-1:0] elem_active,
  output logic [dic_pkg::NEL-1:0] elem_sig_out
);

  localparam int NIN = dic_pkg::NIN;
  localparam int NEL = dic_pkg::NEL;
  localparam int NSY = NIN + 2 * NEL;

  // picks input n (1-based) of v; 0 or past the end reads as 0
  function automatic logic pick(input logic [NIN-1:0] v,
                                input logic [5:0] n);
    pick = 1'b0;
    for (int k = 0; k < NIN; k++) begin
      if (n == 6'(k + 1)) begin
        pick = v[k];
      end
    end
  endfunction

  function automatic logic [14:0] win_ms(input logic [4:0] s);
    win_ms = 15'(dic_pkg::clamp6({1'b0, s}, dic_pkg::WIN_MIN,
                                 dic_pkg::WIN_MAX)) * 15'(dic_pkg::MS_PER_S);
  endfunction

  function automatic logic [9:0] thr(input logic [2:0] lvl);
    case (lvl)
      dic_pkg::LVL_48: thr = dic_pkg::THR_48;
      dic_pkg::LVL_125: thr = dic_pkg::THR_125;
      dic_pkg::LVL_125H: thr = dic_pkg::THR_125H;
      dic_pkg::LVL_250: thr = dic_pkg::THR_250;
      default: thr = dic_pkg::THR_24;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [15:0] fcfg_r;
  logic [NIN-1:0] fsel_r;
  logic [NIN-1:0] auto_r;
  logic [31:0] ccfg_r;
  logic [NEL-1:0] svc_r;
  logic [31:0] esrc_r;
  logic [31:0] lmap_r;
  logic [dic_pkg::NIRQ-1:0] ien_r;
  logic [dic_pkg::NIRQ-1:0] ist_r;

  // bus state
  logic acc;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic [31:0] rd_mux;

  // input path
  logic [NSY-1:0] sync1_r;
  logic [NSY-1:0] sync2_r;
  logic [NIN-1:0] pin_s;
  logic [15:0] tick_cnt_r;
  logic ms_tick_r;
  logic [1:0] stb;
  logic [3:0] ns [2];
  logic [NIN-1:0] filt_r;
  logic [NIN-1:0] filt_d_r;
  logic [3:0] dcnt_r [NIN];
  logic [NIN-1:0] chg;

  // chatter supervision
  dic_pkg::dic_chat_e st_r [NIN];
  logic [5:0] ccnt_r [NIN];
  logic [14:0] tmr_r [NIN];
  logic [NIN-1:0] lk;
  logic [NIN-1:0] lk_d_r;
  logic [NIN-1:0] en_cmd;
  logic [5:0] dch;
  logic [5:0] ech;
  logic [14:0] wdis;
  logic [14:0] wen;

  // supply and elements
  logic sup_ok;
  logic sup_ok_r;
  logic [NEL-1:0] elat_r;
  logic [NEL-1:0] e_on;
  logic [NEL-1:0] e_off;
  logic [NEL-1:0] en_nxt;
  logic [NEL-1:0] act_nxt;
  logic [dic_pkg::NIRQ-1:0] evt;

  dic_filt_if f1 ();
  dic_filt_if f2 ();

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  // writes land in the data phase with no wait; reads add one wait state
  // so that a read right after a write sees the new value
  assign acc = hsel && hready && htrans[1];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= '0;
      hreadyout <= 1'b1;
      hrdata <= '0;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= acc && hwrite;
      rd_pend_r <= acc && !hwrite;
      hreadyout <= !(acc && !hwrite);
      hresp <= 1'b0;
      if (acc) begin
        addr_r <= {haddr[7:2], 2'b00};
      end
      if (rd_pend_r) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    case (addr_r)
      dic_pkg::OFF_CTRL: rd_mux = ctrl_r;
      dic_pkg::OFF_FCFG: rd_mux = {16'h0000, fcfg_r};
      dic_pkg::OFF_FSEL: rd_mux = 32'(fsel_r);
      dic_pkg::OFF_AUTO: rd_mux = 32'(auto_r);
      dic_pkg::OFF_CCFG: rd_mux = ccfg_r;
      dic_pkg::OFF_STAT: rd_mux = 32'(di_value)
                                  | (32'(lk) << dic_pkg::STAT_LCK)
                                  | (32'(sup_ok_r) << dic_pkg::STAT_SOK);
      dic_pkg::OFF_IST: rd_mux = 32'(ist_r);
      dic_pkg::OFF_IEN: rd_mux = 32'(ien_r);
      dic_pkg::OFF_SVC: rd_mux = 32'(svc_r);
      dic_pkg::OFF_ESRC: rd_mux = esrc_r;
      dic_pkg::OFF_LMAP: rd_mux = lmap_r;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= dic_pkg::CTRL_RST;
      fcfg_r <= dic_pkg::FCFG_RST;
      fsel_r <= '0;
      auto_r <= dic_pkg::AUTO_RST;
      ccfg_r <= dic_pkg::CCFG_RST;
      svc_r <= '0;
      esrc_r <= '0;
      lmap_r <= '0;
      ien_r <= '0;
    end else if (wr_pend_r) begin
      case (addr_r)
        dic_pkg::OFF_CTRL: ctrl_r <= {22'h00_0000, hwdata[9:0]};
        dic_pkg::OFF_FCFG: fcfg_r <= hwdata[15:0];
        dic_pkg::OFF_FSEL: fsel_r <= hwdata[NIN-1:0];
        dic_pkg::OFF_AUTO: auto_r <= hwdata[NIN-1:0];
        dic_pkg::OFF_CCFG: ccfg_r <= hwdata & 32'h1f3f_1f3f;
        dic_pkg::OFF_IEN: ien_r <= hwdata[dic_pkg::NIRQ-1:0];
        dic_pkg::OFF_SVC: svc_r <= hwdata[NEL-1:0];
        dic_pkg::OFF_ESRC: esrc_r <= hwdata;
        dic_pkg::OFF_LMAP: lmap_r <= hwdata;
        default: ;
      endcase
    end
  end

  assign en_cmd = (wr_pend_r && addr_r == dic_pkg::OFF_ENCMD) ?
                  hwdata[NIN-1:0] : '0;

  // ----------------------------------------------------------------------
  // synchronisers and millisecond tick
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {panel_off, panel_on, contact_inputs};
      sync2_r <= sync1_r;
    end
  end

  assign pin_s = sync2_r[NIN-1:0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else if (tick_cnt_r == 16'(TICK_CYC - 1)) begin
      tick_cnt_r <= '0;
      ms_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      ms_tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // debounce filters
  // ----------------------------------------------------------------------
  dic_filter u_filt1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .ms_tick(ms_tick_r),
    .per_cfg(fcfg_r[dic_pkg::FCFG_PER1 +: 4]),
    .ns_cfg(fcfg_r[dic_pkg::FCFG_NS1 +: 4]),
    .f(f1.gen)
  );

  dic_filter u_filt2 (
    .clk(clk),
    .sys_rst(sys_rst),
    .ms_tick(ms_tick_r),
    .per_cfg(fcfg_r[dic_pkg::FCFG_PER2 +: 4]),
    .ns_cfg(fcfg_r[dic_pkg::FCFG_NS2 +: 4]),
    .f(f2.gen)
  );

  assign stb = {f2.strobe, f1.strobe};
  assign ns[0] = f1.nsamp;
  assign ns[1] = f2.nsamp;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      filt_r <= '0;
      filt_d_r <= '0;
      dcnt_r <= '{default: '0};
    end else begin
      filt_d_r <= filt_r;
      for (int i = 0; i < NIN; i++) begin
        if (stb[fsel_r[i]]) begin
          if (pin_s[i] == filt_r[i]) begin
            dcnt_r[i] <= '0;
          end else if (dcnt_r[i] + 4'h1 >= ns[fsel_r[i]]) begin
            filt_r[i] <= pin_s[i];
            dcnt_r[i] <= '0;
          end else begin
            dcnt_r[i] <= dcnt_r[i] + 4'h1;
          end
        end
      end
    end
  end

  assign chg = filt_r ^ filt_d_r;

  // ----------------------------------------------------------------------
  // chatter supervision
  // ----------------------------------------------------------------------
  assign dch = dic_pkg::clamp6(ccfg_r[dic_pkg::CCFG_DCH +: 6],
                               dic_pkg::CHG_MIN, dic_pkg::CHG_MAX);
  assign ech = dic_pkg::clamp6(ccfg_r[dic_pkg::CCFG_ECH +: 6],
                               dic_pkg::CHG_MIN, dic_pkg::CHG_MAX);
  assign wdis = win_ms(ccfg_r[dic_pkg::CCFG_DT +: 5]);
  assign wen = win_ms(ccfg_r[dic_pkg::CCFG_ET +: 5]);

  // the disable window opens at the first change, the enable window at lock; both tick in whole milliseconds
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '{default: dic_pkg::CH_FREE};
      ccnt_r <= '{default: '0};
      tmr_r <= '{default: '0};
    end else begin
      for (int i = 0; i < NIN; i++) begin
        case (st_r[i])
          dic_pkg::CH_FREE: begin
            if (chg[i]) begin
              if (auto_r[i] && tmr_r[i] != '0
                  && ccnt_r[i] + 6'h01 > dch) begin
                st_r[i] <= dic_pkg::CH_LOCKED;
                ccnt_r[i] <= '0;
                tmr_r[i] <= wen;
              end else if (tmr_r[i] == '0) begin
                ccnt_r[i] <= 6'h01;
                tmr_r[i] <= wdis;
              end else if (ccnt_r[i] != 6'h3f) begin
                ccnt_r[i] <= ccnt_r[i] + 6'h01;
              end
            end else if (ms_tick_r && tmr_r[i] != '0) begin
              tmr_r[i] <= tmr_r[i] - 15'h0001;
              if (tmr_r[i] == 15'h0001) begin
                ccnt_r[i] <= '0;
              end
            end
          end
          dic_pkg::CH_LOCKED: begin
            if (en_cmd[i] || !auto_r[i]) begin
              st_r[i] <= dic_pkg::CH_FREE;
              ccnt_r[i] <= '0;
              tmr_r[i] <= '0;
            end else if (ms_tick_r && tmr_r[i] == 15'h0001) begin
              ccnt_r[i] <= '0;
              if (ccnt_r[i] <= ech) begin
                st_r[i] <= dic_pkg::CH_FREE;
                tmr_r[i] <= '0;
              end else begin
                tmr_r[i] <= wen;
              end
            end else begin
              if (ms_tick_r) begin
                tmr_r[i] <= tmr_r[i] - 15'h0001;
              end
              if (chg[i] && ccnt_r[i] != 6'h3f) begin
                ccnt_r[i] <= ccnt_r[i] + 6'h01;
              end
            end
          end
          default: st_r[i] <= dic_pkg::CH_FREE;
        endcase
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NIN; i++) begin
      lk[i] = (st_r[i] == dic_pkg::CH_LOCKED);
    end
  end

  // ----------------------------------------------------------------------
  // supply supervision and validated outputs
  // ----------------------------------------------------------------------
  // the reference input is read before any freezing, otherwise a lost
  // supply could never be seen to come back
  assign sup_ok = (!ctrl_r[dic_pkg::CTRL_SUP]
                   || vdc_volts >= thr(ctrl_r[dic_pkg::CTRL_LVL +: 3]))
                  && (ctrl_r[dic_pkg::CTRL_SEL +: 6] == 6'h00
                   || pick(filt_r, ctrl_r[dic_pkg::CTRL_SEL +: 6]));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      di_value <= '0;
      di_valid <= '0;
      sup_ok_r <= 1'b1;
      lk_d_r <= '0;
    end else begin
      sup_ok_r <= sup_ok;
      lk_d_r <= lk;
      for (int i = 0; i < NIN; i++) begin
        di_valid[i] <= sup_ok && !lk[i];
        if (sup_ok && !lk[i]) begin
          di_value[i] <= filt_r[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      logic_in <= '0;
    end else begin
      for (int k = 0; k < dic_pkg::NLOG; k++) begin
        logic_in[k] <= pick(di_value, {2'b00, lmap_r[k * 4 +: 4]});
      end
    end
  end

  // ----------------------------------------------------------------------
  // element enable
  // ----------------------------------------------------------------------
  assign e_on = sync2_r[NIN +: NEL] | ((wr_pend_r
                && addr_r == dic_pkg::OFF_ECMD) ? hwdata[NEL-1:0] : '0);
  assign e_off = sync2_r[NIN + NEL +: NEL] | ((wr_pend_r
                 && addr_r == dic_pkg::OFF_ECMD) ?
                 hwdata[dic_pkg::ECMD_OFF +: NEL] : '0);

  // off wins over on: a stuck button must not hold an element in service
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      elat_r <= '1;
    end else begin
      elat_r <= (elat_r | e_on) & ~e_off;
    end
  end

  always_comb begin
    for (int e = 0; e < NEL; e++) begin
      case (esrc_r[e * dic_pkg::ESRC_W +: 2])
        dic_pkg::SRC_INPUT: en_nxt[e] = pick(di_value, {2'b00,
          esrc_r[e * dic_pkg::ESRC_W + dic_pkg::ESRC_IDX +: 4]});
        dic_pkg::SRC_LATCH: en_nxt[e] = elat_r[e];
        default: en_nxt[e] = 1'b1;
      endcase
      act_nxt[e] = svc_r[e] && en_nxt[e];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      elem_active <= '0;
      elem_sig_out <= '0;
    end else begin
      elem_active <= act_nxt;
      elem_sig_out <= elem_sig_raw & act_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  assign evt[dic_pkg::IRQ_CHG] = |chg;
  assign evt[dic_pkg::IRQ_LOCK] = |(lk & ~lk_d_r);
  assign evt[dic_pkg::IRQ_UNLK] = |(~lk & lk_d_r);
  assign evt[dic_pkg::IRQ_SUP] = sup_ok_r && !sup_ok;

  // a new event in the clearing cycle stays set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ist_r <= '0;
      irq <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~((wr_pend_r && addr_r == dic_pkg::OFF_ICLR) ?
                hwdata[dic_pkg::NIRQ-1:0] : '0)) | evt;
      irq <= |(ist_r & ien_r);
    end
  end

endmodule

/* core/dic_pkg.sv */
// Purpose: constants, types and helpers of the digital input conditioner
// Assumes: 40 MHz clk, AHB-Lite register access, word transfers only
// Notes:   offsets are byte addresses of aligned 32-bit words
//
// Overview of operation
// - each filter samples its inputs every 2 to 10 ms, default 6 ms.
// - a filtered input follows only after 1..10 equal samples, def 2.
// - a per-input select bit picks filter 1 (0) or filter 2 (1).
// - too many changes within the disable window lock and freeze it.
// - a locked input returns after a quiet enable window or a command.
// - lockout acts only on inputs whose auto-disable bit is 1.
// - with supply control on, low supply invalidates every input.
// - supply level codes 0..4 stand for 24/48/125/125(>65%)/250 V.
// - a nonzero selector names a reference input that gates every input, itself included.
// - each logic signal takes at most one physical input.
// - an unassigned element enable reads as logic 1.
// - enables come from panel buttons, an input level or commands.
// - an element out of service drives none of its signals.
package dic_pkg;

  localparam int NIN = 8;
  localparam int NEL = 4;
  localparam int NLOG = 8;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int MS_PER_S = 1000;

  // --------------------------------------------------------------------
  // setting limits
  // --------------------------------------------------------------------
  localparam logic [5:0] PER_MIN = 6'h02;
  localparam logic [5:0] PER_MAX = 6'h0a;
  localparam logic [5:0] SAMP_MIN = 6'h01;
  localparam logic [5:0] SAMP_MAX = 6'h0a;
  localparam logic [5:0] CHG_MIN = 6'h02;
  localparam logic [5:0] CHG_MAX = 6'h3c;
  localparam logic [5:0] WIN_MIN = 6'h01;
  localparam logic [5:0] WIN_MAX = 6'h1e;

  // supply level codes and their activation thresholds in volts
  localparam logic [2:0] LVL_24 = 3'h0;
  localparam logic [2:0] LVL_48 = 3'h1;
  localparam logic [2:0] LVL_125 = 3'h2;
  localparam logic [2:0] LVL_125H = 3'h3;
  localparam logic [2:0] LVL_250 = 3'h4;
  localparam logic [9:0] THR_24 = 10'h012;
  localparam logic [9:0] THR_48 = 10'h024;
  localparam logic [9:0] THR_125 = 10'h05e;
  localparam logic [9:0] THR_125H = 10'h051;
  localparam logic [9:0] THR_250 = 10'h0bc;

  // --------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FCFG = 8'h04;
  localparam logic [7:0] OFF_FSEL = 8'h08;
  localparam logic [7:0] OFF_AUTO = 8'h0c;
  localparam logic [7:0] OFF_CCFG = 8'h10;
  localparam logic [7:0] OFF_ENCMD = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_IST = 8'h1c;
  localparam logic [7:0] OFF_ICLR = 8'h20;
  localparam logic [7:0] OFF_IEN = 8'h24;
  localparam logic [7:0] OFF_SVC = 8'h28;
  localparam logic [7:0] OFF_ESRC = 8'h2c;
  localparam logic [7:0] OFF_ECMD = 8'h30;
  localparam logic [7:0] OFF_LMAP = 8'h34;

  localparam int CTRL_SUP = 0;
  localparam int CTRL_LVL = 1;
  localparam int CTRL_SEL = 4;
  localparam int FCFG_PER1 = 0;
  localparam int FCFG_NS1 = 4;
  localparam int FCFG_PER2 = 8;
  localparam int FCFG_NS2 = 12;
  localparam int CCFG_DCH = 0;
  localparam int CCFG_DT = 8;
  localparam int CCFG_ECH = 16;
  localparam int CCFG_ET = 24;
  localparam int STAT_LCK = 8;
  localparam int STAT_SOK = 16;
  localparam int ECMD_OFF = 8;
  localparam int ESRC_W = 8;
  localparam int ESRC_IDX = 2;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] FCFG_RST = 16'h2626;
  localparam logic [31:0] CCFG_RST = 32'h0205_0205;
  localparam logic [7:0] AUTO_RST = 8'hff;

  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_INPUT = 2'h1;
  localparam logic [1:0] SRC_LATCH = 2'h2;

  localparam int IRQ_CHG = 0;
  localparam int IRQ_LOCK = 1;
  localparam int IRQ_UNLK = 2;
  localparam int IRQ_SUP = 3;
  localparam int NIRQ = 4;

  typedef enum logic {CH_FREE, CH_LOCKED} dic_chat_e;

  function automatic logic [5:0] clamp6(input logic [5:0] v,
                                        input logic [5:0] lo,
                                        input logic [5:0] hi);
    clamp6 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

endpackage

/* core/dic_filt_if.sv */
// Purpose: sample strobe and sample count of one input filter
// Assumes: strobe is a one-cycle pulse on clk
// Notes:   gen drives, sink reads
interface dic_filt_if;
  logic strobe;
  logic [3:0] nsamp;
  modport gen (output strobe, output nsamp);
  modport sink (input strobe, input nsamp);
endinterface

/* core/dic_filter.sv */
// Purpose: sampling period generator of one input filter
// Assumes: ms_tick is a one-cycle pulse every millisecond
// Notes:   out-of-range settings are clamped to the legal range
module dic_filter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ms_tick,
  input wire logic [3:0] per_cfg,
  input wire logic [3:0] ns_cfg,
  dic_filt_if.gen f
);

  logic [3:0] per;
  logic [3:0] pcnt_r;
  logic stb_r;

  assign per = 4'(dic_pkg::clamp6({2'b00, per_cfg}, dic_pkg::PER_MIN,
                                  dic_pkg::PER_MAX));
  assign f.nsamp = 4'(dic_pkg::clamp6({2'b00, ns_cfg}, dic_pkg::SAMP_MIN,
                                      dic_pkg::SAMP_MAX));
  assign f.strobe = stb_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pcnt_r <= '0;
      stb_r <= 1'b0;
    end else begin
      stb_r <= 1'b0;
      if (ms_tick) begin
        if (pcnt_r + 4'h1 >= per) begin
          pcnt_r <= '0;
          stb_r <= 1'b1;
        end else begin
          pcnt_r <= pcnt_r + 4'h1;
        end
      end
    end
  end

endmodule

/* verif/dic_contacts_model.sv */
// Purpose: field contacts wired to the conditioner inputs
// Assumes: steady levels and chatter masks come from the bench
// Notes: a chattering bit flips every 256 clk, slower than one sample
module dic_contacts_model (
  input wire logic clk,
  input wire logic [7:0] level,
  input wire logic [7:0] chatter,
  output logic [7:0] contact_inputs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r = 8'h00;
  logic tog_r = 1'b0;
  always_ff @(posedge clk) cnt_r <= cnt_r + 8'h01;
  always_ff @(posedge clk) if (cnt_r == 8'hff) tog_r <= !tog_r;
  // slow bounce so the fastest filter sees every flip
  assign contact_inputs = level ^ (chatter & {8{tog_r}});
endmodule

/* verif/dic_top_assertions.sv */
// Purpose: port checks of the input conditioner
// Assumes: one clk domain, register writes answer with zero wait
// Notes: shadows the in-service and supply control registers
module dic_top_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [9:0] vdc_volts,
  input wire logic [3:0] elem_sig_raw,
  input wire logic [7:0] di_value,
  input wire logic [7:0] di_valid,
  input wire logic [3:0] elem_active,
  input wire logic [3:0] elem_sig_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] ph_r;
  logic [3:0] svc_r;
  logic [3:0] ctl_r;
  logic low;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_r <= 9'h000;
      svc_r <= 4'h0;
      ctl_r <= 4'h0;
    end else begin
      if (hready)
        ph_r <= {hsel & htrans[1] & hwrite, haddr[7:0]};
      if (ph_r == {1'b1, dic_pkg::OFF_SVC})
        svc_r <= hwdata[3:0];
      if (ph_r == {1'b1, dic_pkg::OFF_CTRL})
        ctl_r <= hwdata[3:0];
    end
  end
  // lowest threshold for other codes: never flags a healthy supply
  assign low = ctl_r[0] && vdc_volts < ((ctl_r[3:1] == dic_pkg::LVL_250) ?
    dic_pkg::THR_250 : dic_pkg::THR_24);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sig_gate_a: assert property (
    elem_sig_out == ($past(elem_sig_raw) & elem_active)) else $error("gate");
  sig_mask_a: assert property (
    (elem_sig_out & ~elem_active) == 4'h0) else $error("inactive output");
  elem_svc_a: assert property (
    (elem_active & ~$past(svc_r)) == 4'h0) else $error("active off service");
  frozen_hold_a: assert property (
    ((di_value ^ $past(di_value)) & ~di_valid & ~$past(di_valid)) == 8'h00)
    else $error("invalid input moved");
  filt_spacing_a: assert property (
    $changed(di_value[2]) |=> $stable(di_value[2]) [*8]) else $error("fast");
  supply_cut_a: assert property (
    low [*3] |-> di_valid == 8'h00) else $error("valid on low supply");
  rd_wait_a: assert property (
    !hreadyout |=> hreadyout) else $error("long wait");
  bus_okay_a: assert property (
    hresp == 1'b0) else $error("error response");
endmodule
bind dic_top dic_top_assertions i_dic_top_assertions (
  .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hreadyout(hreadyout), .hresp(hresp), .vdc_volts(vdc_volts),
  .elem_sig_raw(elem_sig_raw), .di_value(di_value), .di_valid(di_valid),
  .elem_active(elem_active), .elem_sig_out(elem_sig_out));

/* verif/test_dic_top.sv */
// Purpose: self-checking bench of the input conditioner
// Assumes: 1 ms tick shortened to 40 clk
// Notes: registers reached through a simple bus master task
module test_dic_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [7:0] level = 8'h00;
  logic [7:0] chatter = 8'h00;
  logic [9:0] vdc_volts = 10'h0c8;
  logic [3:0] panel_on = 4'h0;
  logic [3:0] panel_off = 4'h0;
  logic [3:0] elem_sig_raw = 4'hf;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, irq;
  logic [7:0] contact_inputs, di_value, di_valid, logic_in;
  logic [3:0] elem_active, elem_sig_out;
  int err_count = 0;
  int n_checks = 0;
  int tick = 0;
  dic_top #(.TICK_CYC(40)) i_dic_top (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq(irq), .contact_inputs(contact_inputs), .vdc_volts(vdc_volts),
    .panel_on(panel_on), .panel_off(panel_off),
    .elem_sig_raw(elem_sig_raw), .di_value(di_value), .di_valid(di_valid),
    .logic_in(logic_in), .elem_active(elem_active),
    .elem_sig_out(elem_sig_out));
  dic_contacts_model i_dic_contacts_model (.clk(clk), .level(level),
    .chatter(chatter), .contact_inputs(contact_inputs));
  initial forever #12.5 clk = !clk;
  task automatic conclude;
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic t_filter;
    rd(dic_pkg::OFF_FCFG, 32'h0000_2626);
    ahb(1'b1, dic_pkg::OFF_FCFG, 32'h0000_3a26);
    ahb(1'b1, dic_pkg::OFF_FSEL, 32'h0000_0008);
    ahb(1'b1, dic_pkg::OFF_LMAP, 32'h0000_0333);
    level <= 8'h0c;
    cyc(200);
    chk(di_value, 8'h00);
    cyc(400);
    chk(di_value, 8'h04);
    cyc(800);
    chk(di_value, 8'h0c);
    chk(logic_in, 8'h07);
  endtask
  task automatic t_supply;
    ahb(1'b1, dic_pkg::OFF_IEN, 32'h0000_0008);
    ahb(1'b1, dic_pkg::OFF_CTRL, 32'h0000_0009);
    vdc_volts <= dic_pkg::THR_250 - 10'h001;
    cyc(5);
    chk(di_valid, 8'h00);
    chk(irq, 1'b1);
    vdc_volts <= dic_pkg::THR_250;
    cyc(5);
    chk(di_valid, 8'hff);
    ahb(1'b1, dic_pkg::OFF_IEN, 32'h0000_0000);
    cyc(2);
    chk(irq, 1'b0);
    ahb(1'b1, dic_pkg::OFF_ICLR, 32'h0000_0008);
    rd(dic_pkg::OFF_IST, 32'h0000_0001);
    ahb(1'b1, dic_pkg::OFF_CTRL, 32'h0000_0010);
    cyc(3);
    chk(di_valid, 8'h00);
    chk(di_value, 8'h0c);
    ahb(1'b1, dic_pkg::OFF_CTRL, 32'h0000_0040);
    cyc(3);
    chk(di_valid, 8'hff);
    ahb(1'b1, dic_pkg::OFF_CTRL, 32'h0000_0000);
  endtask
  task automatic t_chatter;
    rd(dic_pkg::OFF_AUTO, 32'h0000_00ff);
    ahb(1'b1, dic_pkg::OFF_AUTO, 32'h0000_00fd);
    ahb(1'b1, dic_pkg::OFF_FCFG, 32'h0000_3a12);
    ahb(1'b1, dic_pkg::OFF_CCFG, 32'h0105_0102);
    ahb(1'b1, dic_pkg::OFF_IEN, 32'h0000_0002);
    chatter <= 8'h03;
    cyc(1500);
    chk(di_valid, 8'hfe);
    chk(irq, 1'b1);
    chatter <= 8'h00;
    ahb(1'b1, dic_pkg::OFF_ENCMD, 32'h0000_0001);
    cyc(300);
    chk(di_valid, 8'hff);
    chk(di_value, 8'h0c);
    ahb(1'b1, dic_pkg::OFF_ICLR, 32'h0000_0002);
    cyc(2);
    chk(irq, 1'b0);
  endtask
  task automatic t_elem;
    ahb(1'b1, dic_pkg::OFF_SVC, 32'h0000_0003);
    cyc(2);
    chk(elem_active, 4'h3);
    ahb(1'b1, dic_pkg::OFF_ESRC, 32'h0000_020d);
    ahb(1'b1, dic_pkg::OFF_ECMD, 32'h0000_0200);
    cyc(2);
    chk(elem_active, 4'h1);
    ahb(1'b1, dic_pkg::OFF_ECMD, 32'h0000_0002);
    panel_off <= 4'h1;
    cyc(6);
    chk(elem_active, 4'h3);
    level <= 8'h08;
    cyc(300);
    chk(elem_active, 4'h2);
    chk(elem_sig_out, 4'h2);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(8'h3c, 32'h0000_0000);
    t_filter;
    t_supply;
    t_chatter;
    t_elem;
    conclude;
  end
  // run takes about 4000 clk; the ceiling leaves ample margin
  always @(posedge clk) begin
    tick++;
    if (tick == 20000) begin
      err_count++;
      conclude;
    end
  end
endmodule
